// *** port_pkg.sv ***
// constants, types and mode decoding for the strobed parallel port
`default_nettype none
package port_pkg;
    localparam logic [2:0] OFS_PORT_A   = 3'h0;
    localparam logic [2:0] OFS_PORT_B   = 3'h1;
    localparam logic [2:0] OFS_PORT_C   = 3'h2;
    localparam logic [2:0] OFS_CTRL     = 3'h3;
    localparam logic [2:0] OFS_IRQ_STAT = 3'h4;
    localparam logic [2:0] OFS_IRQ_CLR  = 3'h5;
    localparam logic [2:0] OFS_IRQ_EN   = 3'h6;
    localparam int CW_MODE_SET = 7;
    localparam int CW_A_BIDIR  = 6;
    localparam int CW_A_STROBE = 5;
    localparam int CW_A_DIR    = 4;
    localparam int CW_CU_DIR   = 3;
    localparam int CW_B_STROBE = 2;
    localparam int CW_B_DIR    = 1;
    localparam int CW_CL_DIR   = 0;
    localparam int PC_A_WAIT = 7;
    localparam int PC_A_ACK  = 6;
    localparam int PC_A_HELD = 5;
    localparam int PC_A_STB  = 4;
    localparam int PC_A_REQ  = 3;
    localparam int PC_B_HS   = 2;
    localparam int PC_B_FLAG = 1;
    localparam int PC_B_REQ  = 0;
    localparam int IRQ_A_IN  = 0;
    localparam int IRQ_A_OUT = 1;
    localparam int IRQ_B     = 2;
    localparam int IRQ_W     = 3;
    localparam logic [7:0] CW_RESET = 8'h9b;
    typedef enum logic [1:0]
    {
        A_SIMPLE  = 2'b00,
        A_STROBED = 2'b01,
        A_BIDIR   = 2'b11
    } group_a_mode_e;
    typedef struct packed
    {
        group_a_mode_e a_mode;
        logic          a_in;
        logic          cu_in;
        logic          b_strobed;
        logic          b_in;
        logic          cl_in;
    } mode_s;
    function automatic mode_s cw_decode(input logic [7:0] d);
        mode_s m;
        m.a_mode    = d[CW_A_BIDIR] ? A_BIDIR : (d[CW_A_STROBE] ? A_STROBED : A_SIMPLE);
        m.a_in      = d[CW_A_DIR];
        m.cu_in     = d[CW_CU_DIR];
        m.b_strobed = d[CW_B_STROBE];
        m.b_in      = d[CW_B_DIR];
        m.cl_in     = d[CW_CL_DIR];
        return m;
    endfunction : cw_decode
    localparam mode_s MODE_RESET = cw_decode(CW_RESET);
endpackage : port_pkg
`default_nettype wire

// *** handshake_chan.sv ***
// one strobed handshake channel: pending flag, request and peer edge
`default_nettype none
module handshake_chan
(
    // clock and reset
    input  wire logic CLK,
    input  wire logic RESET,
    // configuration
    input  wire logic active,
    input  wire logic is_out,
    input  wire logic irq_en,
    input  wire logic flush,
    // peer and host events
    input  wire logic peer_n,
    input  wire logic host_hit,
    // status
    output logic      held,
    output logic      req,
    output logic      done
);
    logic peer_q;
    logic held_q;
    logic held_d;
    wire  peer_fall = active & peer_q & ~peer_n;
    wire  set_ev    = active & (is_out ? host_hit : peer_fall);
    wire  clr_ev    = is_out ? peer_fall : host_hit;

    // set wins over clear; a mode word wins over both
    always_comb
    begin
        held_d = held_q;
        if (flush)
            held_d = 1'b0;
        else if (set_ev)
            held_d = 1'b1;
        else if (clr_ev)
            held_d = 1'b0;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            peer_q <= 1'b1;
            held_q <= 1'b0;
        end
        else
        begin
            peer_q <= peer_n;
            held_q <= held_d;
        end
    end

    assign held = held_q;
    assign done = peer_fall;
    assign req  = active & irq_en & peer_n & ~host_hit
                & (is_out ? ~held_q : held_q);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    property p_held_on_strobe;
        active && !is_out && peer_fall && !flush |=> held;
    endproperty
    a_held_on_strobe: assert property (p_held_on_strobe)
        else $error("held flag missed strobe fall");

    property p_ack_empties;
        active && is_out && peer_fall && !host_hit && !flush |=> !held;
    endproperty
    a_ack_empties: assert property (p_ack_empties)
        else $error("acknowledge did not clear waiting flag");
endmodule : handshake_chan
`default_nettype wire

// *** strobed_bidir_port_ctrl.sv ***
// parallel port controller with strobed bidirectional group A
//
// Added by the designer: the address-and-strobe port and the register offsets.
`default_nettype none
module strobed_bidir_port_ctrl
#(
    parameter int DATA_W = 8
)
(
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RESET,
    // register port
    input  wire logic [2:0]        ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DATA_W-1:0] RDATA,
    // port A pins
    input  wire logic [DATA_W-1:0] PA_I,
    output logic      [DATA_W-1:0] PA_O,
    output logic                   PA_OE,
    // port B pins
    input  wire logic [DATA_W-1:0] PB_I,
    output logic      [DATA_W-1:0] PB_O,
    output logic                   PB_OE,
    // port C pins, per-bit enable
    input  wire logic [7:0]        PC_I,
    output logic      [7:0]        PC_O,
    output logic      [7:0]        PC_OE,
    // interrupt
    output logic                   IRQ
);
    if (DATA_W != 8)
        $error("port width must be 8");

    port_pkg::mode_s     mode_q;
    logic [DATA_W-1:0]   a_out_q;
    logic [DATA_W-1:0]   a_in_q;
    logic [DATA_W-1:0]   b_out_q;
    logic [DATA_W-1:0]   b_in_q;
    logic [7:0]          pc_q;
    logic                inte_a_in_q;
    logic                inte_a_out_q;
    logic                inte_b_q;
    logic [port_pkg::IRQ_W-1:0] irq_stat_q;
    logic [port_pkg::IRQ_W-1:0] irq_stat_d;
    logic [port_pkg::IRQ_W-1:0] irq_en_q;
    logic [DATA_W-1:0]   rdata_q;
    logic [DATA_W-1:0]   rd_val;
    logic [7:0]          pc_out;
    logic [7:0]          pc_oe;
    logic [7:0]          pc_rd;

    // address decode
    wire hit_a_rd  = RD & (ADDR == port_pkg::OFS_PORT_A);
    wire hit_a_wr  = WR & (ADDR == port_pkg::OFS_PORT_A);
    wire hit_b_rd  = RD & (ADDR == port_pkg::OFS_PORT_B);
    wire hit_b_wr  = WR & (ADDR == port_pkg::OFS_PORT_B);
    wire hit_c_wr  = WR & (ADDR == port_pkg::OFS_PORT_C);
    wire hit_ctrl  = WR & (ADDR == port_pkg::OFS_CTRL);
    wire hit_clr   = WR & (ADDR == port_pkg::OFS_IRQ_CLR);
    wire hit_en    = WR & (ADDR == port_pkg::OFS_IRQ_EN);
    wire mode_wr   = hit_ctrl & WDATA[port_pkg::CW_MODE_SET];
    wire bsr_wr    = hit_ctrl & ~WDATA[port_pkg::CW_MODE_SET];
    wire [2:0] bsr_bit = WDATA[3:1];

    // group roles
    wire a_bidir    = mode_q.a_mode == port_pkg::A_BIDIR;
    wire a_strb     = mode_q.a_mode == port_pkg::A_STROBED;
    wire a_in_side  = a_bidir | (a_strb & mode_q.a_in);
    wire a_out_side = a_bidir | (a_strb & ~mode_q.a_in);
    wire b_strb     = mode_q.b_strobed;

    logic a_held;
    logic a_in_req;
    logic a_in_done;
    logic a_wait;
    logic a_out_req;
    logic a_out_done;
    logic b_flag;
    logic b_req;
    logic b_done;
    wire  a_req = a_in_req | a_out_req;

    handshake_chan u_a_in
    (
        .CLK      (CLK),
        .RESET    (RESET),
        .active   (a_in_side),
        .is_out   (1'b0),
        .irq_en   (inte_a_in_q),
        .flush    (mode_wr),
        .peer_n   (PC_I[port_pkg::PC_A_STB]),
        .host_hit (hit_a_rd),
        .held     (a_held),
        .req      (a_in_req),
        .done     (a_in_done)
    );

    handshake_chan u_a_out
    (
        .CLK      (CLK),
        .RESET    (RESET),
        .active   (a_out_side),
        .is_out   (1'b1),
        .irq_en   (inte_a_out_q),
        .flush    (mode_wr),
        .peer_n   (PC_I[port_pkg::PC_A_ACK]),
        .host_hit (hit_a_wr),
        .held     (a_wait),
        .req      (a_out_req),
        .done     (a_out_done)
    );

    // group B runs on its own, whatever group A does
    handshake_chan u_b
    (
        .CLK      (CLK),
        .RESET    (RESET),
        .active   (b_strb),
        .is_out   (~mode_q.b_in),
        .irq_en   (inte_b_q),
        .flush    (mode_wr),
        .peer_n   (PC_I[port_pkg::PC_B_HS]),
        .host_hit (mode_q.b_in ? hit_b_rd : hit_b_wr),
        .held     (b_flag),
        .req      (b_req),
        .done     (b_done)
    );

    // port C pin roles and control readback
    wire [7:0] gen_oe = {{4{~mode_q.cu_in}}, {4{~mode_q.cl_in}}};

    always_comb
    begin
        pc_out = pc_q;
        pc_oe  = gen_oe;
        pc_rd  = (pc_q & gen_oe) | (PC_I & ~gen_oe);
        if (a_out_side)
        begin
            pc_out[port_pkg::PC_A_WAIT] = ~a_wait;
            pc_oe[port_pkg::PC_A_WAIT]  = 1'b1;
            pc_oe[port_pkg::PC_A_ACK]   = 1'b0;
            pc_rd[port_pkg::PC_A_WAIT]  = ~a_wait;
            pc_rd[port_pkg::PC_A_ACK]   = inte_a_out_q;
        end
        if (a_in_side)
        begin
            pc_out[port_pkg::PC_A_HELD] = a_held;
            pc_oe[port_pkg::PC_A_HELD]  = 1'b1;
            pc_oe[port_pkg::PC_A_STB]   = 1'b0;
            pc_rd[port_pkg::PC_A_HELD]  = a_held;
            pc_rd[port_pkg::PC_A_STB]   = inte_a_in_q;
        end
        if (a_bidir | a_strb)
        begin
            pc_out[port_pkg::PC_A_REQ] = a_req;
            pc_oe[port_pkg::PC_A_REQ]  = 1'b1;
            pc_rd[port_pkg::PC_A_REQ]  = a_req;
        end
        if (b_strb)
        begin
            pc_out[port_pkg::PC_B_FLAG] = mode_q.b_in ? b_flag : ~b_flag;
            pc_oe[port_pkg::PC_B_FLAG]  = 1'b1;
            pc_oe[port_pkg::PC_B_HS]    = 1'b0;
            pc_out[port_pkg::PC_B_REQ]  = b_req;
            pc_oe[port_pkg::PC_B_REQ]   = 1'b1;
            pc_rd[port_pkg::PC_B_HS]    = inte_b_q;
            pc_rd[port_pkg::PC_B_FLAG]  = pc_out[port_pkg::PC_B_FLAG];
            pc_rd[port_pkg::PC_B_REQ]   = b_req;
        end
    end

    assign PC_O = pc_out;
    assign PC_OE = pc_oe;

    // in bidirectional mode port A floats until the peer acknowledges; otherwise the direction bit alone sets PA_OE
    assign PA_O  = a_out_q;
    assign PA_OE = a_bidir ? ~PC_I[port_pkg::PC_A_ACK] : ~mode_q.a_in;
    assign PB_O  = b_out_q;
    assign PB_OE = ~mode_q.b_in;

    // interrupt status, set wins over clear
    wire [port_pkg::IRQ_W-1:0] irq_ev = {b_done, a_out_done, a_in_done};
    wire [port_pkg::IRQ_W-1:0] irq_clr =
        hit_clr ? WDATA[port_pkg::IRQ_W-1:0] : {port_pkg::IRQ_W{1'b0}};
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;
    assign IRQ = |(irq_stat_q & irq_en_q);

    // read mux
    wire [DATA_W-1:0] a_rd = a_in_side ? a_in_q : (mode_q.a_in ? PA_I : a_out_q);
    wire [DATA_W-1:0] b_rd = mode_q.b_in ? (b_strb ? b_in_q : PB_I) : b_out_q;

    always_comb
    begin
        rd_val = '0;
        if (ADDR == port_pkg::OFS_PORT_A)
            rd_val = a_rd;
        else if (ADDR == port_pkg::OFS_PORT_B)
            rd_val = b_rd;
        else if (ADDR == port_pkg::OFS_PORT_C)
            rd_val = pc_rd;
        else if (ADDR == port_pkg::OFS_IRQ_STAT)
            rd_val = {{(DATA_W-port_pkg::IRQ_W){1'b0}}, irq_stat_q};
        else if (ADDR == port_pkg::OFS_IRQ_EN)
            rd_val = {{(DATA_W-port_pkg::IRQ_W){1'b0}}, irq_en_q};
    end

    assign RDATA = rdata_q;

    // host data and mode registers
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            mode_q  <= port_pkg::MODE_RESET;
            a_out_q <= '0;
            b_out_q <= '0;
            rdata_q <= '0;
        end
        else
        begin
            if (mode_wr)
                mode_q <= port_pkg::cw_decode(WDATA);
            if (hit_a_wr)
                a_out_q <= WDATA;
            if (hit_b_wr)
                b_out_q <= WDATA;
            rdata_q <= RD ? rd_val : '0;
        end
    end

    // captures from the peer
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            a_in_q <= '0;
            b_in_q <= '0;
        end
        else
        begin
            if (a_in_done)
                a_in_q <= PA_I;
            if (b_done & mode_q.b_in)
                b_in_q <= PB_I;
        end
    end

    // port C latch and request enables
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            pc_q         <= '0;
            inte_a_in_q  <= 1'b0;
            inte_a_out_q <= 1'b0;
            inte_b_q     <= 1'b0;
        end
        else if (mode_wr)
        begin
            inte_a_in_q  <= 1'b0;
            inte_a_out_q <= 1'b0;
            inte_b_q     <= 1'b0;
        end
        else if (hit_c_wr)
            pc_q <= WDATA;
        else if (bsr_wr)
        begin
            pc_q[bsr_bit] <= WDATA[0];
            if (bsr_bit == 3'(port_pkg::PC_A_STB) && a_in_side)
                inte_a_in_q <= WDATA[0];
            if (bsr_bit == 3'(port_pkg::PC_A_ACK) && a_out_side)
                inte_a_out_q <= WDATA[0];
            if (bsr_bit == 3'(port_pkg::PC_B_HS) && b_strb)
                inte_b_q <= WDATA[0];
        end
    end

    // interrupt registers
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            irq_stat_q <= '0;
            irq_en_q   <= '0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            if (hit_en)
                irq_en_q <= WDATA[port_pkg::IRQ_W-1:0];
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    property p_float_idle;
        a_bidir && PC_I[port_pkg::PC_A_ACK] |-> !PA_OE;
    endproperty
    a_float_idle: assert property (p_float_idle)
        else $error("port A driven without acknowledge");

    property p_drive_on_ack;
        a_bidir && !PC_I[port_pkg::PC_A_ACK] |-> PA_OE && PA_O == a_out_q;
    endproperty
    a_drive_on_ack: assert property (p_drive_on_ack)
        else $error("port A not driven during acknowledge");

    property p_wait_low;
        a_bidir && hit_a_wr |=> !PC_O[port_pkg::PC_A_WAIT] && PC_OE[port_pkg::PC_A_WAIT];
    endproperty
    a_wait_low: assert property (p_wait_low)
        else $error("waiting line not low after write");

    sequence s_strobe;
        a_bidir && !mode_wr && $fell(PC_I[port_pkg::PC_A_STB]);
    endsequence
    property p_capture;
        s_strobe |=> a_in_q == $past(PA_I) && PC_O[port_pkg::PC_A_HELD];
    endproperty
    a_capture: assert property (p_capture)
        else $error("strobe did not capture port A");

    sequence s_read_a;
        a_bidir && hit_a_rd;
    endsequence
    property p_read_back;
        s_read_a |=> RDATA == $past(a_in_q) ##1 RDATA == '0 || $past(RD);
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("read of port A returned wrong byte");

    property p_status;
        a_bidir && RD && ADDR == port_pkg::OFS_PORT_C |=> RDATA[7:3] ==
            $past({~a_wait, inte_a_out_q, a_held, inte_a_in_q, a_req});
    endproperty
    a_status: assert property (p_status)
        else $error("bidirectional status layout wrong");

    property p_req;
        a_bidir && a_held && inte_a_in_q && PC_I[port_pkg::PC_A_STB] && !RD
            |-> PC_O[port_pkg::PC_A_REQ];
    endproperty
    a_req_in: assert property (p_req)
        else $error("input-side request missing");

    property p_mode_clear;
        mode_wr |=> !inte_a_in_q && !inte_a_out_q && !inte_b_q && !a_held && !a_wait;
    endproperty
    a_mode_clear: assert property (p_mode_clear)
        else $error("mode word left flags set");

    property p_dir;
        mode_wr && WDATA[6:5] == 2'b00 |=> PA_OE == !$past(WDATA[port_pkg::CW_A_DIR])
            && PB_OE == !$past(WDATA[port_pkg::CW_B_DIR]);
    endproperty
    a_dir: assert property (p_dir)
        else $error("simple mode direction wrong");
endmodule : strobed_bidir_port_ctrl
`default_nettype wire

// *** terminal_unit.sv ***
// terminal unit model: strobe and acknowledge side of port A
`default_nettype none
module terminal_unit
(
    // clock
    input  wire logic       CLK,
    // port A pin level
    input  wire logic [7:0] pa_pin,
    // handshake and data toward the port
    output logic            stb_n,
    output logic            ack_n,
    output logic      [7:0] pa_drv
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        stb_n  = 1'b1;
        ack_n  = 1'b1;
        pa_drv = 8'hff;
    end

    // data stands before, during and after the strobe, then the lines change to the inverted byte
    task automatic send_byte(input logic [7:0] d, input int gap);
        @(posedge CLK);
        pa_drv <= d;
        repeat (gap) @(posedge CLK);
        @(posedge CLK);
        stb_n  <= 1'b0;
        @(posedge CLK);
        stb_n  <= 1'b1;
        @(posedge CLK);
        pa_drv <= ~d;
    endtask : send_byte

    // acknowledge held low for hold plus one cycles, port A sampled before acknowledge is released
    task automatic take_byte(input int hold, output logic [7:0] d);
        @(posedge CLK);
        ack_n <= 1'b0;
        repeat (hold) @(posedge CLK);
        @(posedge CLK);
        d = pa_pin;
        ack_n <= 1'b1;
    endtask : take_byte
endmodule : terminal_unit
`default_nettype wire

// *** strobed_bidir_port_ctrl_bench.sv ***
// self-checking testbench for the strobed bidirectional port controller
`default_nettype none
module strobed_bidir_port_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       CLK   = 1'b0;
    logic       RESET = 1'b1;
    logic [2:0] ADDR  = 3'h0;
    logic [7:0] WDATA = 8'h00;
    logic       WR    = 1'b0;
    logic       RD    = 1'b0;
    logic [7:0] RDATA, PA_O, PB_O, PC_O, PC_OE, pa_drv;
    logic       PA_OE, PB_OE, IRQ, ack_n, stb_n;
    logic [7:0] v;
    int         mismatches = 0;
    int         checks     = 0;
    // wire levels: whoever enables drives, else pull-ups or the far side
    wire  [7:0] pa_pin = PA_OE ? PA_O : pa_drv;
    wire  [7:0] pb_pin = PB_OE ? PB_O : 8'hc3;
    wire  [7:0] pc_ext = {1'b1, ack_n, 1'b1, stb_n, 4'hf};
    wire  [7:0] pc_pin = (PC_OE & PC_O) | (~PC_OE & pc_ext);

    always #10 CLK = ~CLK;

    strobed_bidir_port_ctrl #(.DATA_W(8)) strobed_bidir_port_ctrl_i
    (
        .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .PA_I(pa_pin), .PA_O(PA_O), .PA_OE(PA_OE), .PB_I(pb_pin),
        .PB_O(PB_O), .PB_OE(PB_OE), .PC_I(pc_pin), .PC_O(PC_O), .PC_OE(PC_OE), .IRQ(IRQ)
    );

    terminal_unit terminal_unit_i
    (
        .CLK(CLK), .pa_pin(pa_pin), .stb_n(stb_n), .ack_n(ack_n), .pa_drv(pa_drv)
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD   <= 1'b0;
        #1 d = RDATA;
    endtask : rd

    task automatic t_reset();
        #1 check(RDATA, 8'h00);
        check({5'h0, IRQ, PA_OE, PB_OE}, 8'h00);
        check(PC_OE, 8'h00);
    endtask : t_reset

    task automatic t_simple();
        logic [7:0] cw [6] = '{8'h80, 8'h81, 8'h8a, 8'h90, 8'h93, 8'h9b};
        foreach (cw[i])
        begin
            wr(port_pkg::OFS_CTRL, cw[i]);
            #1 check({6'h0, PA_OE, PB_OE}, {6'h0, ~cw[i][4], ~cw[i][1]});
            check(PC_OE, {{4{~cw[i][3]}}, {4{~cw[i][0]}}});
        end
        wr(port_pkg::OFS_CTRL, 8'h80);
        wr(port_pkg::OFS_PORT_A, 8'h6e);
        #1 check(PA_O, 8'h6e);
        wr(port_pkg::OFS_PORT_B, 8'h2d);
        #1 check(PB_O, 8'h2d);
    endtask : t_simple

    task automatic t_bidir_out();
        wr(port_pkg::OFS_CTRL, 8'hc0);
        #1 check({3'h0, PC_OE[7:3]}, 8'h15);
        wr(port_pkg::OFS_PORT_A, 8'h5a);
        #1 check({6'h0, PC_O[7], PA_OE}, 8'h00);
        rd(port_pkg::OFS_PORT_C, v);
        check(v & 8'hf8, 8'h00);
        terminal_unit_i.take_byte(0, v);
        check(v, 8'h5a);
        #1 check({6'h0, PC_O[7], PA_OE}, 8'h02);
    endtask : t_bidir_out

    task automatic t_bidir_in();
        wr(port_pkg::OFS_PORT_A, 8'h3c);
        terminal_unit_i.send_byte(8'ha5, 2);
        #1 check({7'h0, PC_O[5]}, 8'h01);
        rd(port_pkg::OFS_PORT_A, v);
        check(v, 8'ha5);
        check({7'h0, PC_O[5]}, 8'h00);
        terminal_unit_i.take_byte(3, v);
        check(v, 8'h3c);
    endtask : t_bidir_in

    task automatic t_request();
        wr(port_pkg::OFS_CTRL, 8'h0d);
        #1 check({7'h0, PC_O[3]}, 8'h01);
        rd(port_pkg::OFS_PORT_C, v);
        check(v & 8'hf8, 8'hc8);
        wr(port_pkg::OFS_PORT_A, 8'h11);
        #1 check({7'h0, PC_O[3]}, 8'h00);
        wr(port_pkg::OFS_CTRL, 8'h0c);
        wr(port_pkg::OFS_CTRL, 8'h09);
        terminal_unit_i.send_byte(8'h77, 0);
        #1 check({7'h0, PC_O[3]}, 8'h01);
        rd(port_pkg::OFS_PORT_C, v);
        check(v & 8'hf8, 8'h38);
        rd(port_pkg::OFS_PORT_A, v);
        check({PC_O[3], v[6:0]}, 8'h77);
        wr(port_pkg::OFS_CTRL, 8'hc0);
        rd(port_pkg::OFS_PORT_C, v);
        check(v & 8'hf8, 8'h80);
    endtask : t_request

    task automatic t_irq();
        wr(port_pkg::OFS_IRQ_CLR, 8'h07);
        wr(port_pkg::OFS_IRQ_EN, 8'h01);
        terminal_unit_i.send_byte(8'h42, 1);
        #1 check({7'h0, IRQ}, 8'h01);
        rd(port_pkg::OFS_IRQ_STAT, v);
        check(v & 8'h07, 8'h01);
        wr(port_pkg::OFS_IRQ_EN, 8'h00);
        #1 check({7'h0, IRQ}, 8'h00);
        wr(port_pkg::OFS_IRQ_EN, 8'h01);
        #1 check({7'h0, IRQ}, 8'h01);
        wr(port_pkg::OFS_IRQ_CLR, 8'h01);
        #1 check({7'h0, IRQ}, 8'h00);
        rd(port_pkg::OFS_IRQ_STAT, v);
        check(v & 8'h07, 8'h00);
        rd(3'h7, v);
        check(v, 8'h00);
        rd(port_pkg::OFS_IRQ_CLR, v);
        check(v, 8'h00);
        rd(port_pkg::OFS_PORT_A, v);
        check(v, 8'h42);
    endtask : t_irq

    // group A strobed single-direction: input layout, then output layout
    task automatic t_strobed();
        wr(port_pkg::OFS_CTRL, 8'hb6);
        wr(port_pkg::OFS_CTRL, 8'h09);
        wr(port_pkg::OFS_CTRL, 8'h05);
        terminal_unit_i.send_byte(8'he1, 0);
        #1 check({6'h0, PC_O[5], PA_OE}, 8'h02);
        rd(port_pkg::OFS_PORT_C, v);
        check(v & 8'h3f, 8'h3c);
        rd(port_pkg::OFS_PORT_A, v);
        check(v, 8'he1);
        wr(port_pkg::OFS_CTRL, 8'ha0);
        wr(port_pkg::OFS_CTRL, 8'h0d);
        wr(port_pkg::OFS_PORT_A, 8'h99);
        rd(port_pkg::OFS_PORT_C, v);
        check(v & 8'hc8, 8'h40);
        terminal_unit_i.take_byte(1, v);
        check(v, 8'h99);
        rd(port_pkg::OFS_PORT_C, v);
        check(v & 8'hc8, 8'hc8);
    endtask : t_strobed

    task automatic t_group_b();
        logic [7:0] cw [3] = '{8'hc6, 8'hc4, 8'hc2};
        foreach (cw[i])
        begin
            wr(port_pkg::OFS_CTRL, cw[i]);
            #1 check({PC_OE[7:3], 1'b0, PA_OE, PB_OE}, {5'h15, 2'b00, ~cw[i][1]});
        end
    endtask : t_group_b

    initial
    begin
        repeat (16) @(posedge CLK);
        RESET <= 1'b0;
        t_reset();
        t_simple();
        t_bidir_out();
        t_bidir_in();
        t_request();
        t_irq();
        t_strobed();
        t_group_b();
        give_verdict();
    end

    // watchdog well beyond the roughly 140 cycles the sequence needs
    initial
    begin
        repeat (5000) @(posedge CLK);
        mismatches++;
        give_verdict();
    end
endmodule : strobed_bidir_port_ctrl_bench
`default_nettype wire
